// ==== logic/debug_unit_pkg.sv ====
// constants shared by the debug breakpoint and watchpoint unit
// Notes on behaviour
// - saved stack pointer captured on debugger entry
// - eight-bit thread select for register fetch
// - five-bit register select for register fetch
// - three-bit cause code recorded, resets zero
// - lowest firing index recorded, zero otherwise
// - causing thread recorded, zero for host
// - watch address or resource id stored
// - stop vector holds threads outside debug
// - eight scratch words shared with debugger
// - four pc breakpoints with own address
// - control bit one selects equal/unequal
// - enable bit and per-thread mask qualify
// - four data watchpoints with two addresses
// - control bit two enables load triggering
// - control bit one selects and/or combine
// - four resource watchpoints, mask and value
// - control bit one selects condition A/B
// - request bit and in-debug status bit
package debug_unit_pkg;
    // status register indices on the core port
    localparam logic [7:0] IDX_SP = 8'h12;
    localparam logic [7:0] IDX_FETCH_THREAD = 8'h13;
    localparam logic [7:0] IDX_FETCH_REG = 8'h14;
    localparam logic [7:0] IDX_CAUSE = 8'h15;
    localparam logic [7:0] IDX_CAUSE_DATA = 8'h16;
    localparam logic [7:0] IDX_STOP = 8'h18;
    localparam logic [7:0] IDX_SCRATCH = 8'h20;
    localparam logic [7:0] IDX_PC_ADDR = 8'h30;
    localparam logic [7:0] IDX_PC_CTRL = 8'h40;
    localparam logic [7:0] IDX_DW_A = 8'h50;
    localparam logic [7:0] IDX_DW_B = 8'h60;
    localparam logic [7:0] IDX_DW_CTRL = 8'h70;
    localparam logic [7:0] IDX_RW_MASK = 8'h80;
    localparam logic [7:0] IDX_RW_VALUE = 8'h90;
    localparam logic [7:0] IDX_RW_CTRL = 8'h9C;
    // tile configuration map indices
    localparam logic [7:0] CFG_DEBUG_REQ = 8'h05;
    // writable bits of each register
    localparam logic [31:0] MASK_FETCH_THREAD = 32'h0000_00FF;
    localparam logic [31:0] MASK_FETCH_REG = 32'h0000_001F;
    localparam logic [31:0] MASK_CAUSE = 32'h0003_FF07;
    localparam logic [31:0] MASK_STOP = 32'h0000_00FF;
    localparam logic [31:0] MASK_PC_CTRL = 32'h00FF_0003;
    localparam logic [31:0] MASK_DW_CTRL = 32'h00FF_0007;
    localparam logic [31:0] MASK_RW_CTRL = 32'h00FF_0003;
    // control field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_LOAD = 2;
    localparam int CTRL_THREAD_LSB = 16;
    // cause codes
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_HOST = 3'h1;
    localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2;
    localparam logic [2:0] CAUSE_PC = 3'h3;
    localparam logic [2:0] CAUSE_DATA = 3'h4;
    localparam logic [2:0] CAUSE_RES = 3'h5;
    // sizes and reset values
    localparam int NUM_BP = 4;
    localparam int NUM_SCRATCH = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ==== logic/debug_unit.sv ====
// debug breakpoint, watchpoint, cause capture and scratch register block
`timescale 1ns/100ps
module debug_unit
    import debug_unit_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,

    // core status register port
    input wire logic [7:0] ps_addr,
    input wire logic ps_wr,
    input wire logic ps_rd,
    input wire logic [31:0] ps_wdata,
    output logic [31:0] ps_rdata,

    // tile configuration port
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,

    // core state
    input wire logic debug_mode,
    input wire logic debug_entry,
    input wire logic [31:0] entry_sp,

    // instruction issue
    input wire logic exec_valid,
    input wire logic [2:0] exec_thread,
    input wire logic [31:0] exec_pc,
    input wire logic debug_call_instruction_valid,

    // memory access
    input wire logic mem_valid,
    input wire logic mem_load,
    input wire logic [2:0] mem_thread,
    input wire logic [31:0] mem_addr,

    // resource access
    input wire logic res_valid,
    input wire logic [2:0] res_thread,
    input wire logic [31:0] res_id,

    // outputs to the core
    output logic debug_irq,
    output logic host_request,
    output logic [7:0] thread_hold,
    output logic [7:0] fetch_thread,
    output logic [4:0] fetch_reg
);

    // thread is allowed by an enabled control word
    function automatic logic thread_ok(input logic [31:0] ctrl, input logic [2:0] thr);
        thread_ok = ctrl[CTRL_ENABLE] & ctrl[CTRL_THREAD_LSB + 32'(thr)];
    endfunction

    // index of the lowest set hit bit
    function automatic logic [1:0] lowest(input logic [NUM_BP-1:0] hits);
        lowest = 2'h0;
        for (int i = NUM_BP - 1; i >= 0; i--) begin
            if (hits[i]) begin
                lowest = 2'(i);
            end
        end
    endfunction

    // register storage
    logic [31:0] sp_q; // saved stack pointer
    logic [31:0] cause_q; // cause, thread and index
    logic [31:0] cause_data_q; // watch address or resource id
    logic [7:0] stop_q; // thread stop vector
    logic host_req_q; // pending host request
    logic [31:0] scratch_q [NUM_SCRATCH]; // shared scratch words

    // per-slot words, one of each per slot
    logic [31:0] pc_addr_q [NUM_BP];
    logic [31:0] pc_ctrl_q [NUM_BP];
    logic [31:0] dw_a_q [NUM_BP];
    logic [31:0] dw_b_q [NUM_BP];
    logic [31:0] dw_ctrl_q [NUM_BP];
    logic [31:0] rw_mask_q [NUM_BP];
    logic [31:0] rw_val_q [NUM_BP];
    logic [31:0] rw_ctrl_q [NUM_BP];

    // comparison results
    logic [NUM_BP-1:0] pc_hit;
    logic [NUM_BP-1:0] dw_hit;
    logic [NUM_BP-1:0] rw_hit;
    logic armed; // comparisons live
    // chosen event, at most one kind set
    logic ev_pc, ev_dw, ev_rw, ev_debug_call_instruction, ev_host, ev_any;
    logic ps_we; // debug-mode write strobe

    // core writes land only in debug mode
    assign ps_we = clk_en & ps_wr & debug_mode;
    // no new event while in debug or while one is pending
    assign armed = ~debug_mode & ~debug_irq;

    // per-slot comparators
    for (genvar g = 0; g < NUM_BP; g++) begin : g_cmp
        logic dw_ca, dw_cb, dw_cond, dw_kind, rw_eq;
        // pc equal or unequal by mode bit
        assign pc_hit[g] = exec_valid & thread_ok(pc_ctrl_q[g], exec_thread)
            & (pc_ctrl_q[g][CTRL_MODE] ? (exec_pc != pc_addr_q[g])
                                       : (exec_pc == pc_addr_q[g]));

        // address window conditions
        assign dw_ca = mem_addr >= dw_a_q[g];
        assign dw_cb = mem_addr <= dw_b_q[g];
        assign dw_cond = dw_ctrl_q[g][CTRL_MODE] ? (dw_ca | dw_cb) : (dw_ca & dw_cb);

        // loads fire only when the load bit is set, stores always
        assign dw_kind = ~mem_load | dw_ctrl_q[g][CTRL_LOAD];
        assign dw_hit[g] = mem_valid & thread_ok(dw_ctrl_q[g], mem_thread)
            & dw_kind & dw_cond;

        // masked compare, condition B is the mismatch
        assign rw_eq = ((res_id ^ rw_val_q[g]) & rw_mask_q[g]) == 32'h0000_0000;
        assign rw_hit[g] = res_valid & thread_ok(rw_ctrl_q[g], res_thread)
            & (rw_ctrl_q[g][CTRL_MODE] ? ~rw_eq : rw_eq);
    end

    // event priority: pc, data, resource, call, host
    assign ev_pc = armed & (|pc_hit);
    assign ev_dw = armed & ~ev_pc & (|dw_hit);
    assign ev_rw = armed & ~ev_pc & ~ev_dw & (|rw_hit);
    assign ev_debug_call_instruction = armed & ~(|pc_hit) & ~(|dw_hit) & ~(|rw_hit) & exec_valid & debug_call_instruction_valid;
    assign ev_host = armed & ~(|pc_hit) & ~(|dw_hit) & ~(|rw_hit)
        & ~(exec_valid & debug_call_instruction_valid) & host_req_q;
    assign ev_any = ev_pc | ev_dw | ev_rw | ev_debug_call_instruction | ev_host;

    // saved stack pointer: entry capture, debug writes otherwise
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_q <= RESET_WORD;
        end else if (clk_en && debug_entry) begin
            sp_q <= entry_sp;
        end else if (ps_we && ps_addr == IDX_SP) begin
            sp_q <= ps_wdata;
        end
    end

    // register fetch operands
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_thread <= 8'h00;
            fetch_reg <= 5'h00;
        end else if (ps_we) begin
            if (ps_addr == IDX_FETCH_THREAD) begin
                fetch_thread <= ps_wdata[7:0];
            end
            if (ps_addr == IDX_FETCH_REG) begin
                fetch_reg <= ps_wdata[4:0];
            end
        end
    end

    // cause record: hardware event wins over a debug write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cause_q <= RESET_WORD;
        end else if (clk_en && ev_any) begin
            // clear old fields, the winner fills its own
            cause_q <= RESET_WORD;
            if (ev_pc) begin
                cause_q[2:0] <= CAUSE_PC;
                cause_q[15:8] <= {5'h00, exec_thread};
                cause_q[17:16] <= lowest(pc_hit);
            end else if (ev_dw) begin
                cause_q[2:0] <= CAUSE_DATA;
                cause_q[15:8] <= {5'h00, mem_thread};
                cause_q[17:16] <= lowest(dw_hit);
            end else if (ev_rw) begin
                cause_q[2:0] <= CAUSE_RES;
                cause_q[15:8] <= {5'h00, res_thread};
                cause_q[17:16] <= lowest(rw_hit);
            end else if (ev_debug_call_instruction) begin
                cause_q[2:0] <= CAUSE_DEBUG_CALL_INSTRUCTION; // index stays zero
                cause_q[15:8] <= {5'h00, exec_thread};
            end else begin
                cause_q[2:0] <= CAUSE_HOST; // thread and index stay zero
            end
        end else if (ps_we && ps_addr == IDX_CAUSE) begin
            cause_q <= ps_wdata & MASK_CAUSE;
        end
    end

    // cause data: watch address or resource id
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cause_data_q <= RESET_WORD;
        end else if (clk_en && ev_dw) begin
            cause_data_q <= mem_addr;
        end else if (clk_en && ev_rw) begin
            cause_data_q <= res_id;
        end else if (ps_we && ps_addr == IDX_CAUSE_DATA) begin
            cause_data_q <= ps_wdata;
        end
    end

    // thread stop vector and the hold it drives
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_q <= 8'h00;
            thread_hold <= 8'h00;
        end else if (clk_en) begin
            if (ps_we && ps_addr == IDX_STOP) begin
                stop_q <= ps_wdata[7:0];
            end
            // released while debugging, held on return
            thread_hold <= debug_mode ? 8'h00 : stop_q;
        end
    end

    // debug interrupt line: raised by an event, dropped in debug
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            debug_irq <= 1'b0;
        end else if (clk_en) begin
            if (ev_any) begin
                debug_irq <= 1'b1;
            end else if (debug_mode) begin
                debug_irq <= 1'b0;
            end
        end
    end

    // host request bit: a write of one wins over acceptance
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_req_q <= 1'b0;
            host_request <= 1'b0;
        end else if (clk_en) begin
            if (cfg_wr && cfg_addr == CFG_DEBUG_REQ) begin
                host_req_q <= cfg_wdata[0];
                host_request <= cfg_wdata[0];
            end else if (ev_host) begin
                host_req_q <= 1'b0;
                host_request <= 1'b0;
            end
        end
    end

    // scratch words: core write wins over the configuration port
    for (genvar s = 0; s < NUM_SCRATCH; s++) begin : g_scr
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                scratch_q[s] <= RESET_WORD;
            end else if (ps_we && ps_addr == IDX_SCRATCH + 8'(s)) begin
                scratch_q[s] <= ps_wdata;
            end else if (clk_en && cfg_wr && cfg_addr == IDX_SCRATCH + 8'(s)) begin
                scratch_q[s] <= cfg_wdata;
            end
        end
    end

    // breakpoint and watchpoint slot registers
    for (genvar b = 0; b < NUM_BP; b++) begin : g_slot
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                pc_addr_q[b] <= RESET_WORD;
                pc_ctrl_q[b] <= RESET_WORD;
                dw_a_q[b] <= RESET_WORD;
                dw_b_q[b] <= RESET_WORD;
                dw_ctrl_q[b] <= RESET_WORD;
                rw_mask_q[b] <= RESET_WORD;
                rw_val_q[b] <= RESET_WORD;
                rw_ctrl_q[b] <= RESET_WORD;
            end else if (ps_we) begin
                unique case (ps_addr)
                    IDX_PC_ADDR + 8'(b): pc_addr_q[b] <= ps_wdata;
                    IDX_PC_CTRL + 8'(b): pc_ctrl_q[b] <= ps_wdata & MASK_PC_CTRL;
                    IDX_DW_A + 8'(b): dw_a_q[b] <= ps_wdata;
                    IDX_DW_B + 8'(b): dw_b_q[b] <= ps_wdata;
                    IDX_DW_CTRL + 8'(b): dw_ctrl_q[b] <= ps_wdata & MASK_DW_CTRL;
                    IDX_RW_MASK + 8'(b): rw_mask_q[b] <= ps_wdata;
                    IDX_RW_VALUE + 8'(b): rw_val_q[b] <= ps_wdata;
                    IDX_RW_CTRL + 8'(b): rw_ctrl_q[b] <= ps_wdata & MASK_RW_CTRL;
                    default: ; // other indices leave the slot alone
                endcase
            end
        end
    end

    // core port read mux, registered, unmapped reads zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ps_rdata <= RESET_WORD;
        end else if (clk_en && ps_rd) begin
            ps_rdata <= RESET_WORD;
            if (ps_addr == IDX_SP) ps_rdata <= sp_q;
            if (ps_addr == IDX_FETCH_THREAD) ps_rdata <= {24'h000000, fetch_thread};
            if (ps_addr == IDX_FETCH_REG) ps_rdata <= {27'h0, fetch_reg};
            if (ps_addr == IDX_CAUSE) ps_rdata <= cause_q;
            if (ps_addr == IDX_CAUSE_DATA) ps_rdata <= cause_data_q;
            if (ps_addr == IDX_STOP) ps_rdata <= {24'h000000, stop_q};

            // scratch words, then the slot words
            for (int i = 0; i < NUM_SCRATCH; i++) begin
                if (ps_addr == IDX_SCRATCH + 8'(i)) ps_rdata <= scratch_q[i];
            end

            for (int i = 0; i < NUM_BP; i++) begin
                if (ps_addr == IDX_PC_ADDR + 8'(i)) ps_rdata <= pc_addr_q[i];
                if (ps_addr == IDX_PC_CTRL + 8'(i)) ps_rdata <= pc_ctrl_q[i];
                if (ps_addr == IDX_DW_A + 8'(i)) ps_rdata <= dw_a_q[i];
                if (ps_addr == IDX_DW_B + 8'(i)) ps_rdata <= dw_b_q[i];
                if (ps_addr == IDX_DW_CTRL + 8'(i)) ps_rdata <= dw_ctrl_q[i];
                if (ps_addr == IDX_RW_MASK + 8'(i)) ps_rdata <= rw_mask_q[i];
                if (ps_addr == IDX_RW_VALUE + 8'(i)) ps_rdata <= rw_val_q[i];
                if (ps_addr == IDX_RW_CTRL + 8'(i)) ps_rdata <= rw_ctrl_q[i];
            end
        end
    end

    // configuration port read mux
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata <= RESET_WORD;
        end else if (clk_en && cfg_rd) begin
            cfg_rdata <= RESET_WORD;
            if (cfg_addr == CFG_DEBUG_REQ) begin
                cfg_rdata <= {30'h0, debug_mode, host_req_q};
            end

            // scratch words mirror the core port
            for (int i = 0; i < NUM_SCRATCH; i++) begin
                if (cfg_addr == IDX_SCRATCH + 8'(i)) cfg_rdata <= scratch_q[i];
            end
        end
    end

    // checks on captured state
    AST_SP_CAPTURE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && debug_entry |=> sp_q == $past(entry_sp))
        else $error("stack pointer not captured on entry");

    AST_SP_GUARD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !debug_mode && !debug_entry |=> $stable(sp_q))
        else $error("stack pointer changed outside debug mode");

    AST_PC_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && armed && (|pc_hit) |=> cause_q[2:0] == CAUSE_PC && debug_irq)
        else $error("pc breakpoint cause not recorded");

    AST_LOWEST_INDEX: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && armed && (pc_hit[0] || (!(|pc_hit) && dw_hit[0]))
        |=> cause_q[17:16] == 2'h0)
        else $error("lowest slot index not taken");

    AST_HOST_THREAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && ev_host |=> cause_q[2:0] == CAUSE_HOST && cause_q[17:8] == 10'h0)
        else $error("host cause carries a thread or index");

    AST_DATA_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && ev_dw |=> cause_data_q == $past(mem_addr))
        else $error("watch address not stored");

    AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && !debug_mode ##1 clk_en && !debug_mode |=> thread_hold == $past(stop_q))
        else $error("stop vector not applied outside debug mode");

    AST_QUIET_DEBUG: assert property (@(posedge sys_clk) disable iff (!rst_b)
        debug_mode && !ps_wr |=> $stable(cause_q))
        else $error("cause changed while in debug mode");

    AST_STATUS_BIT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && cfg_rd && cfg_addr == CFG_DEBUG_REQ |=> cfg_rdata[1] == $past(debug_mode))
        else $error("debug mode status bit wrong");

endmodule

// ==== tb/debugger_model.sv ====
// external debugger model driving the tile configuration port
`timescale 1ns/100ps
module debugger_model (
    // clock
    input wire logic sys_clk,
    // requests to the device
    output logic [7:0] cfg_addr,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [31:0] cfg_wdata,
    // answer from the device
    input wire logic [31:0] cfg_rdata
);
    // idle at time zero
    initial begin
        cfg_addr = 8'h00;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_wdata = 32'h0;
    end
    // write after a chosen stall; released data is scrambled
    task automatic cfg_write(input logic [7:0] a, input logic [31:0] d, input int stall);
        repeat (stall + 1) @(posedge sys_clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        cfg_wdata <= ~d;
    endtask
    // read; the answer lands on the taken edge and is sampled one cycle later
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
        @(posedge sys_clk);
        #1 d = cfg_rdata;
    endtask
endmodule

// ==== tb/debug_unit_bench.sv ====
// random and directed checks of the debug breakpoint and watchpoint unit
`timescale 1ns/100ps
module debug_unit_bench;
    import debug_unit_pkg::*;
    // clock, reset and core port
    logic sys_clk, rst_b, ps_wr, ps_rd;
    logic [7:0] ps_addr, cfg_addr;
    logic [31:0] ps_wdata, ps_rdata, cfg_wdata, cfg_rdata;
    logic cfg_wr, cfg_rd, debug_mode, debug_entry, clk_en;
    // core traffic
    logic exec_valid, debug_call_instruction_valid, mem_valid, mem_load, res_valid;
    logic [2:0] exec_thread, mem_thread, res_thread;
    logic [31:0] entry_sp, exec_pc, mem_addr, res_id;
    // outputs
    logic debug_irq, host_request;
    logic [7:0] thread_hold, fetch_thread, stop_exp;
    logic [4:0] fetch_reg;
    // bookkeeping
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] lfsr_q, v, got, pc, lo;
    // register table: index and readable bits, last one unmapped
    logic [7:0] idx_tab [10] = '{IDX_SP, IDX_FETCH_THREAD, IDX_FETCH_REG, IDX_CAUSE, IDX_STOP,
        IDX_PC_ADDR + 8'h3, IDX_PC_CTRL, IDX_DW_CTRL, IDX_RW_CTRL, 8'h1F};
    logic [31:0] msk_tab [10] = '{32'hFFFF_FFFF, 32'h0000_00FF, 32'h0000_001F, 32'h0003_FF07,
        32'h0000_00FF, 32'hFFFF_FFFF, 32'h00FF_0003, 32'h00FF_0007, 32'h00FF_0003, 32'h0};
    // data watch cases: control, load, offset from first address, fires
    logic [31:0] dw_ctrl [6] = '{32'h00FF_0001, 32'h00FF_0001, 32'h00FF_0005, 32'h00FF_0001,
        32'h00FF_0003, 32'h00FF_0001};
    logic dw_load [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [31:0] dw_off [6] = '{32'h8, 32'h8, 32'h0, 32'h104, 32'h104, 32'h100};
    logic dw_hit [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    // resource watch cases: control, id flip, fires
    logic [31:0] rw_ctrl [4] = '{32'h0020_0001, 32'h0020_0003, 32'h0020_0003, 32'h0020_0001};
    logic [31:0] rw_flip [4] = '{32'h0000_FF00, 32'h0000_FF00, 32'h1, 32'h1};
    logic rw_hit [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    // device under test
    debug_unit dut (.sys_clk, .rst_b, .clk_en, .ps_addr, .ps_wr, .ps_rd, .ps_wdata,
        .ps_rdata, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .debug_mode,
        .debug_entry, .entry_sp, .exec_valid, .exec_thread, .exec_pc, .debug_call_instruction_valid,
        .mem_valid, .mem_load, .mem_thread, .mem_addr, .res_valid, .res_thread, .res_id,
        .debug_irq, .host_request, .thread_hold, .fetch_thread, .fetch_reg);
    // external debugger on the configuration port
    debugger_model dbg (.sys_clk, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata);

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // verdict and end of run
    task automatic summarize();
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // word comparison
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string what);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask
    // next random word
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    // expected cause word from index, thread and code
    function automatic logic [31:0] cw(input logic [1:0] i, input logic [2:0] t, input logic [2:0] c);
        return {14'h0, i, 5'h0, t, 5'h0, c};
    endfunction
    // core register write
    task automatic ps_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        ps_addr <= a;
        ps_wdata <= d;
        ps_wr <= 1'b1;
        @(posedge sys_clk);
        ps_wr <= 1'b0;
    endtask
    // core register read and compare
    task automatic ps_check(input logic [7:0] a, input logic [31:0] e, input string what);
        @(posedge sys_clk);
        ps_addr <= a;
        ps_rd <= 1'b1;
        @(posedge sys_clk);
        ps_rd <= 1'b0;
        @(posedge sys_clk);
        #1 cmp(ps_rdata, e, what);
    endtask
    // one cycle of traffic outside debug mode, then back into debug mode
    task automatic fire(input int kind, input logic [31:0] c, input logic [31:0] d, input logic hit);
        @(posedge sys_clk);
        debug_mode <= 1'b0;
        exec_valid <= (kind < 2);
        debug_call_instruction_valid <= (kind == 1);
        mem_valid <= (kind == 2);
        res_valid <= (kind == 3);
        @(posedge sys_clk);
        {exec_valid, debug_call_instruction_valid, mem_valid, res_valid} <= 4'h0;
        @(posedge sys_clk);
        #1 cmp({31'h0, debug_irq}, {31'h0, hit}, "irq");
        cmp({24'h0, thread_hold}, {24'h0, stop_exp}, "hold");
        @(posedge sys_clk);
        debug_mode <= 1'b1;
        if (hit) begin
            ps_check(IDX_CAUSE, c, "cause");
            if (kind == 2 || kind == 3) ps_check(IDX_CAUSE_DATA, d, "data");
        end
        repeat (2) @(posedge sys_clk);
        #1 cmp({23'h0, debug_irq, thread_hold}, 32'h0, "leave");
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        {ps_wr, ps_rd, debug_entry, exec_valid, debug_call_instruction_valid, mem_valid, mem_load} = 7'h0;
        {res_valid, clk_en} = 2'h1;
        debug_mode = 1'b1;
        ps_addr = 8'h00;
        {ps_wdata, entry_sp, exec_pc, mem_addr, res_id} = 160'h0;
        {exec_thread, mem_thread, res_thread} = 9'h0;
        stop_exp = 8'h24;
        lfsr_q = 32'h48A8;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        // reset values, then random writes read back through the field masks
        for (int i = 0; i < 10; i++) ps_check(idx_tab[i], 32'h0, "reset");
        for (int i = 0; i < 10; i++) begin
            v = rnd();
            ps_write(idx_tab[i], v);
            ps_check(idx_tab[i], v & msk_tab[i], "rw");
        end
        for (int i = 6; i < 9; i++) ps_write(idx_tab[i], 32'h0);
        ps_write(IDX_STOP, 32'h24);
        // register fetch operands
        v = rnd();
        ps_write(IDX_FETCH_THREAD, v);
        ps_write(IDX_FETCH_REG, v);
        clk_en <= 1'b0; // frozen: this write is dropped
        ps_write(IDX_FETCH_REG, ~v);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        #1 cmp({19'h0, fetch_reg, fetch_thread}, {19'h0, v[4:0], v[7:0]}, "fetch");
        // stack pointer capture, then a refused write outside debug mode
        @(posedge sys_clk);
        debug_entry <= 1'b1;
        entry_sp <= v;
        @(posedge sys_clk);
        debug_entry <= 1'b0;
        debug_mode <= 1'b0;
        ps_write(IDX_SP, ~v);
        debug_mode <= 1'b1;
        ps_check(IDX_SP, v, "sp");
        // scratch words seen from both ports
        for (int i = 0; i < NUM_SCRATCH; i++) begin
            v = rnd();
            ps_write(IDX_SCRATCH + 8'(i), v);
            dbg.cfg_read(IDX_SCRATCH + 8'(i), got);
            cmp(got, v, "scratch");
            dbg.cfg_write(IDX_SCRATCH + 8'(i), ~v, i % 3);
            ps_check(IDX_SCRATCH + 8'(i), ~v, "scratch");
        end
        // two pc breakpoints on one address, lowest index wins
        pc = rnd();
        ps_write(IDX_PC_ADDR + 8'h1, pc);
        ps_write(IDX_PC_ADDR + 8'h2, pc);
        ps_write(IDX_PC_CTRL + 8'h1, 32'h0008_0001);
        ps_write(IDX_PC_CTRL + 8'h2, 32'h00FF_0001);
        exec_pc <= pc;
        exec_thread <= 3'h3;
        fire(0, cw(2'h1, 3'h3, CAUSE_PC), 32'h0, 1'b1);
        exec_thread <= 3'h4;
        fire(0, cw(2'h2, 3'h4, CAUSE_PC), 32'h0, 1'b1);
        ps_write(IDX_PC_CTRL + 8'h2, 32'h0);
        fire(0, 32'h0, 32'h0, 1'b0);
        ps_write(IDX_PC_CTRL + 8'h1, 32'h0008_0003);
        exec_thread <= 3'h3;
        fire(0, 32'h0, 32'h0, 1'b0);
        exec_pc <= pc + 32'h4;
        fire(0, cw(2'h1, 3'h3, CAUSE_PC), 32'h0, 1'b1);
        // a hit while already in debug mode is ignored
        @(posedge sys_clk);
        exec_valid <= 1'b1;
        @(posedge sys_clk);
        exec_valid <= 1'b0;
        @(posedge sys_clk);
        #1 cmp({31'h0, debug_irq}, 32'h0, "irq");
        ps_write(IDX_PC_CTRL + 8'h1, 32'h0);
        // data watchpoint range, load qualifier and combine mode
        lo = rnd() & 32'h7FFF_FFF0;
        ps_write(IDX_DW_A, lo);
        ps_write(IDX_DW_B, lo + 32'h100);
        mem_thread <= 3'h2;
        for (int i = 0; i < 6; i++) begin
            ps_write(IDX_DW_CTRL, dw_ctrl[i]);
            mem_load <= dw_load[i];
            mem_addr <= lo + dw_off[i];
            fire(2, cw(2'h0, 3'h2, CAUSE_DATA), lo + dw_off[i], dw_hit[i]);
        end
        ps_write(IDX_DW_CTRL, 32'h0);
        // resource watchpoint, masked match and mismatch conditions
        v = rnd();
        ps_write(IDX_RW_MASK + 8'h3, 32'hFFFF_00FF);
        ps_write(IDX_RW_VALUE + 8'h3, v);
        res_thread <= 3'h5;
        for (int i = 0; i < 4; i++) begin
            ps_write(IDX_RW_CTRL + 8'h3, rw_ctrl[i]);
            res_id <= v ^ rw_flip[i];
            fire(3, cw(2'h3, 3'h5, CAUSE_RES), v ^ rw_flip[i], rw_hit[i]);
        end
        ps_write(IDX_RW_CTRL + 8'h3, 32'h0);
        // debug call, then a host request held pending until debug mode drops
        exec_thread <= 3'h6;
        fire(1, cw(2'h0, 3'h6, CAUSE_DEBUG_CALL_INSTRUCTION), 32'h0, 1'b1);
        dbg.cfg_write(CFG_DEBUG_REQ, 32'h3, 1);
        @(posedge sys_clk);
        #1 cmp({31'h0, host_request}, 32'h1, "request");
        fire(4, cw(2'h0, 3'h0, CAUSE_HOST), 32'h0, 1'b1);
        dbg.cfg_read(CFG_DEBUG_REQ, got);
        cmp(got, 32'h2, "status");
        dbg.cfg_read(8'h06, got);
        cmp(got, 32'h0, "unmapped");
        summarize();
    end
endmodule
